// file: core/smm_top.sv
`timescale 1ns/1ps
`default_nettype none
module smm_top (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic phy_mode_in,
  input wire logic [4:0] ext_port_address_in,
  input wire logic mac_mdc_in,
  input wire logic mac_mdo_in,
  input wire logic mac_mdo_en_in,
  output logic mac_mdin_out,
  output logic emb_mdc_out,
  output logic emb_mdio_out,
  input wire logic emb_mdio_in,
  input wire logic link_up_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic mdc_in,
  output logic mdc_out,
  output logic mdc_oe_n_out,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n_out,
  output logic [4:0] ext_media_addr_out,
  output logic phy_mode_out
);
  smm_frame_if fr ();

  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic mdio_s1;
  logic mdio_s2;
  logic mode_s1;
  logic mode_s2;
  logic mode_taken;
  logic phy_mode;
  logic mac_mdc_q;
  logic [15:0] ctrl;
  logic [15:0] shift;
  logic own_drv;
  logic own_bit;
  logic is_emb;
  logic is_ext;
  logic rd_phase;
  logic emb_fwd;

  // read word for the status responder
  function automatic logic [15:0] reg_word(input logic [4:0] ra, input logic [15:0] c, input logic lnk,
                                           input logic spd, input logic dpx);
    logic [15:0] w;
    w = 16'h0000;
    if (ra == smm_pkg::REG_CTRL) begin
      w = c;
    end else if (ra == smm_pkg::REG_STATUS) begin
      w = smm_pkg::STATUS_BASE;
      w[smm_pkg::STATUS_LINK_BIT] = lnk;
    end else if (ra == smm_pkg::REG_SPECIAL) begin
      w[smm_pkg::SPECIAL_SPEED_BIT] = spd;
      w[smm_pkg::SPECIAL_DUPLEX_BIT] = dpx;
    end
    reg_word = w;
  endfunction

  smm_frame_parser u_parser (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .fr(fr)
  );

  // pin synchronisers; the link clock is only sampled here
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= mdc_in;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
    end
  end

  // strap sync kept out of reset so the level is already through it at release
  always_ff @(posedge core_clk_in) begin
    mode_s1 <= phy_mode_in;
    mode_s2 <= mode_s1;
  end

  // strap caught once after release; a later change of the pin is ignored
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_taken <= 1'b0;
      phy_mode <= 1'b0;
    end else if (!mode_taken) begin
      mode_taken <= 1'b1;
      phy_mode <= mode_s2;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mac_mdc_q <= 1'b0;
    end else begin
      mac_mdc_q <= mac_mdc_in;
    end
  end

  // frame source: own mac in MAC mode, outside mac in PHY mode
  assign fr.rise = phy_mode ? (mdc_s2 & ~mdc_s3) : (mac_mdc_in & ~mac_mdc_q);
  assign fr.bit_val = phy_mode ? mdio_s2 : mac_mdo_in;

  assign is_emb = fr.phy_addr == smm_pkg::EMB_PHY_ADDR;
  assign is_ext = !is_emb && fr.phy_addr == smm_pkg::smm_ext_addr(phy_mode, ext_port_address_in);
  assign rd_phase = fr.op == smm_pkg::OP_READ && (fr.phase == smm_pkg::SMM_TURN || fr.phase == smm_pkg::SMM_DATA);
  assign emb_fwd = rd_phase && is_emb && (fr.phase == smm_pkg::SMM_DATA || fr.cnt == smm_pkg::TURN_LAST);

  // control word written by the outside mac
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= smm_pkg::CTRL_RESET;
    end else if (phy_mode && fr.done && fr.op == smm_pkg::OP_WRITE && is_ext
                 && fr.reg_addr == smm_pkg::REG_CTRL) begin
      ctrl <= fr.wdata;
    end
  end

  // status responder: zero in the second turnaround bit, then 16 data bits
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      own_drv <= 1'b0;
      own_bit <= 1'b1;
      shift <= 16'h0000;
    end else if (!phy_mode || !(fr.phase == smm_pkg::SMM_TURN || fr.phase == smm_pkg::SMM_DATA)) begin
      own_drv <= 1'b0;
    end else if (fr.rise) begin
      if (fr.phase == smm_pkg::SMM_TURN && fr.cnt == 4'h0) begin
        own_drv <= fr.op == smm_pkg::OP_READ && is_ext;
        own_bit <= 1'b0;
        shift <= reg_word(fr.reg_addr, ctrl, link_up_in, speed_100_in, full_duplex_in);
      end else if (fr.phase == smm_pkg::SMM_DATA && fr.cnt == smm_pkg::DATA_LAST) begin
        own_drv <= 1'b0;
      end else begin
        own_bit <= shift[15];
        shift <= {shift[14:0], 1'b0};
      end
    end
  end

  // clock pin: driven in MAC mode, an input in PHY mode
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mdc_out <= 1'b0;
      mdc_oe_n_out <= 1'b1;
    end else if (phy_mode) begin
      mdc_out <= 1'b0;
      mdc_oe_n_out <= 1'b1;
    end else begin
      mdc_out <= mac_mdc_in;
      mdc_oe_n_out <= 1'b0;
    end
  end

  // data pin: own mac in MAC mode, responder or forwarded phy in PHY mode
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mdio_out <= 1'b1;
      mdio_oe_n_out <= 1'b1;
    end else if (phy_mode) begin
      mdio_out <= emb_fwd ? emb_mdio_in : own_bit;
      mdio_oe_n_out <= !(emb_fwd || own_drv);
    end else begin
      mdio_out <= mac_mdo_in;
      mdio_oe_n_out <= !mac_mdo_en_in;
    end
  end

  // embedded phy follows whichever station is active
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      emb_mdc_out <= 1'b0;
      emb_mdio_out <= 1'b1;
    end else if (phy_mode) begin
      emb_mdc_out <= mdc_s2;
      emb_mdio_out <= mdio_s2;
    end else begin
      emb_mdc_out <= mac_mdc_in;
      emb_mdio_out <= mac_mdo_in;
    end
  end

  // embedded phy data only once the mac has let go of the line
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mac_mdin_out <= 1'b1;
    end else if (phy_mode) begin
      mac_mdin_out <= 1'b1;
    end else begin
      mac_mdin_out <= (rd_phase && is_emb && !mac_mdo_en_in) ? emb_mdio_in : mdio_s2;
    end
  end

  // media address follows the programmed value, mode applied
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_media_addr_out <= 5'h00;
    end else begin
      ext_media_addr_out <= smm_pkg::smm_ext_addr(phy_mode, ext_port_address_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phy_mode_out <= 1'b0;
    end else begin
      phy_mode_out <= phy_mode;
    end
  end
endmodule // smm_top
`default_nettype wire

// file: core/smm_pkg.sv
package smm_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] EMB_PHY_ADDR = 5'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PRE_MIN = 6'h20;
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h4;
  localparam logic [3:0] TURN_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_SPECIAL = 5'h1F;
  localparam logic [15:0] CTRL_RESET = 16'h3100;
  localparam logic [15:0] STATUS_BASE = 16'h7809;
  localparam int STATUS_LINK_BIT = 2;
  localparam int SPECIAL_SPEED_BIT = 1;
  localparam int SPECIAL_DUPLEX_BIT = 0;

  typedef enum logic [2:0] {
    SMM_PRE,
    SMM_START,
    SMM_OP,
    SMM_PHYAD,
    SMM_REGAD,
    SMM_TURN,
    SMM_DATA
  } smm_phase_t;

  // external media address per mode
  function automatic logic [4:0] smm_ext_addr(input logic phy_mode, input logic [4:0] sec);
    smm_ext_addr = phy_mode ? {sec[4:1], 1'b0} : sec;
  endfunction
endpackage

// file: core/smm_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smm_frame_if;
  logic rise;
  logic bit_val;
  smm_pkg::smm_phase_t phase;
  logic [3:0] cnt;
  logic [1:0] op;
  logic [4:0] phy_addr;
  logic [4:0] reg_addr;
  logic [15:0] wdata;
  logic done;

  modport parser (input rise, input bit_val, output phase, output cnt, output op, output phy_addr,
                  output reg_addr, output wdata, output done);
  modport user (output rise, output bit_val, input phase, input cnt, input op, input phy_addr,
                input reg_addr, input wdata, input done);
endinterface
`default_nettype wire

// file: core/smm_frame_parser.sv
`timescale 1ns/1ps
`default_nettype none
module smm_frame_parser (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  smm_frame_if.parser fr
);
  logic [5:0] pre_cnt;
  logic [3:0] last;
  smm_pkg::smm_phase_t next_phase;

  always_comb begin
    last = smm_pkg::ADDR_LAST;
    next_phase = smm_pkg::SMM_PRE;
    unique case (fr.phase)
      smm_pkg::SMM_PRE: begin
        next_phase = smm_pkg::SMM_START;
      end
      smm_pkg::SMM_START: begin
        next_phase = smm_pkg::SMM_OP;
      end
      smm_pkg::SMM_OP: begin
        last = smm_pkg::OP_LAST;
        next_phase = smm_pkg::SMM_PHYAD;
      end
      smm_pkg::SMM_PHYAD: begin
        next_phase = smm_pkg::SMM_REGAD;
      end
      smm_pkg::SMM_REGAD: begin
        next_phase = smm_pkg::SMM_TURN;
      end
      smm_pkg::SMM_TURN: begin
        last = smm_pkg::TURN_LAST;
        next_phase = smm_pkg::SMM_DATA;
      end
      smm_pkg::SMM_DATA: begin
        last = smm_pkg::DATA_LAST;
        next_phase = smm_pkg::SMM_PRE;
      end
    endcase
  end

  // frame sequencing, one step per rising management clock
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fr.phase <= smm_pkg::SMM_PRE;
      fr.cnt <= 4'h0;
      pre_cnt <= 6'h00;
    end else if (fr.rise) begin
      if (fr.phase == smm_pkg::SMM_PRE) begin
        fr.cnt <= 4'h0;
        if (fr.bit_val) begin
          if (pre_cnt != smm_pkg::PRE_MIN) begin
            pre_cnt <= pre_cnt + 6'h01;
          end
        end else begin
          pre_cnt <= 6'h00;
          if (pre_cnt == smm_pkg::PRE_MIN) begin
            fr.phase <= next_phase;
          end
        end
      end else if (fr.phase == smm_pkg::SMM_START) begin
        fr.cnt <= 4'h0;
        fr.phase <= fr.bit_val ? next_phase : smm_pkg::SMM_PRE;
      end else if (fr.cnt == last) begin
        fr.cnt <= 4'h0;
        fr.phase <= next_phase;
      end else begin
        fr.cnt <= fr.cnt + 4'h1;
      end
    end
  end

  // field capture, msb first
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fr.op <= 2'h0;
      fr.phy_addr <= 5'h00;
      fr.reg_addr <= 5'h00;
      fr.wdata <= 16'h0000;
    end else if (fr.rise) begin
      unique case (fr.phase)
        smm_pkg::SMM_OP: begin
          fr.op <= {fr.op[0], fr.bit_val};
        end
        smm_pkg::SMM_PHYAD: begin
          fr.phy_addr <= {fr.phy_addr[3:0], fr.bit_val};
        end
        smm_pkg::SMM_REGAD: begin
          fr.reg_addr <= {fr.reg_addr[3:0], fr.bit_val};
        end
        smm_pkg::SMM_DATA: begin
          fr.wdata <= {fr.wdata[14:0], fr.bit_val};
        end
        default: begin
          fr.op <= fr.op;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fr.done <= 1'b0;
    end else begin
      fr.done <= fr.rise && fr.phase == smm_pkg::SMM_DATA && fr.cnt == smm_pkg::DATA_LAST;
    end
  end
endmodule // smm_frame_parser
`default_nettype wire

// file: verification/smm_props.sv
`timescale 1ns/1ps
`default_nettype none
module smm_props (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] ext_port_address_in,
  input wire logic mac_mdc_in,
  input wire logic mac_mdo_in,
  input wire logic mac_mdo_en_in,
  input wire logic mac_mdin_out,
  input wire logic emb_mdc_out,
  input wire logic emb_mdio_out,
  input wire logic mdio_in,
  input wire logic mdc_out,
  input wire logic mdc_oe_n_out,
  input wire logic mdio_out,
  input wire logic mdio_oe_n_out,
  input wire logic [4:0] ext_media_addr_out,
  input wire logic phy_mode_out
);
  logic [1:0] up;
  logic mac;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // mode settles over the first edges, so checks wait
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  assign mac = up == 2'h3 && !phy_mode_out;
  AST_EXT_ADDR: assert property (up == 2'h3 |->
    ext_media_addr_out == (phy_mode_out ? {$past(ext_port_address_in[4:1]), 1'b0} : $past(ext_port_address_in)))
    else $error("bad media address");
  AST_MODE_HOLD: assert property (up == 2'h3 |-> $stable(phy_mode_out))
    else $error("mode changed");
  AST_MDC_IN: assert property (up == 2'h3 && phy_mode_out |-> mdc_oe_n_out && !mdc_out)
    else $error("clock pin driven in phy mode");
  AST_MDC_DRV: assert property (mac |-> !mdc_oe_n_out && mdc_out == $past(mac_mdc_in))
    else $error("clock pin not mirrored");
  AST_MDIO_OE: assert property (mac |-> mdio_oe_n_out == !$past(mac_mdo_en_in))
    else $error("data pin enable wrong");
  AST_MDIO_DAT: assert property (mac && !mdio_oe_n_out |-> mdio_out == $past(mac_mdo_in))
    else $error("data pin value wrong");
  AST_MDIN_PIN: assert property (mac_mdo_en_in [*4] ##0 mac |-> mac_mdin_out == $past(mdio_in, 3))
    else $error("read data not from pin");
  AST_EMB_CLK: assert property (mac |-> emb_mdc_out == $past(mac_mdc_in))
    else $error("embedded clock wrong");
  AST_EMB_DAT: assert property (mac |-> emb_mdio_out == $past(mac_mdo_in))
    else $error("embedded data wrong");
endmodule // smm_props
bind smm_top smm_props u_props (.core_clk_in, .rstn_in, .ext_port_address_in, .mac_mdc_in, .mac_mdo_in,
  .mac_mdo_en_in, .mac_mdin_out, .emb_mdc_out, .emb_mdio_out, .mdio_in, .mdc_out, .mdc_oe_n_out, .mdio_out,
  .mdio_oe_n_out, .ext_media_addr_out, .phy_mode_out);
`default_nettype wire

// file: verification/smm_sta_model.sv
`timescale 1ns/1ps
`default_nettype none
module smm_sta_model (
  input wire logic clk_in,
  input wire logic rd_in,
  output logic mdc_out,
  output logic dat_out,
  output logic en_out,
  output logic win_out
);
  // clock stands low between frames
  initial begin
    mdc_out = 1'b0;
    dat_out = 1'b1;
    en_out = 1'b0;
    win_out = 1'b0;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] f;
    f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 17'h00000;
    @(negedge clk_in);
    for (int i = 0; i < 64; i++) begin
      // released from turnaround on for reads
      en_out = op != smm_pkg::OP_READ || i < 46;
      win_out = !en_out;
      dat_out = f[63-i];
      repeat (8) @(negedge clk_in);
      if (i > 46) rd = {rd[15:0], rd_in};
      mdc_out = 1'b1;
      repeat (8) @(negedge clk_in);
      mdc_out = 1'b0;
    end
    en_out = 1'b0;
    win_out = 1'b0;
  endtask
endmodule // smm_sta_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic b = 1'b0;
  logic lk = 1'b0;
  logic sp = 1'b0;
  logic dx = 1'b0;
  logic [4:0] sec = 5'h00;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  wire logic m_clk, m_dat, m_en, m_win, mdc_o, mdc_oen, mdio_o, mdio_oen, mdin, mode_o;
  wire logic [4:0] ea;
  // released pin floats to the pull-up level
  wire logic mdio_w = !mdio_oen ? mdio_o : (m_en && mode) ? m_dat : (m_win && !mode) ? !b : 1'b1;
  wire logic mdc_w = !mdc_oen ? mdc_o : mode & m_clk;
  smm_top u_dut (.core_clk_in(clk), .rstn_in(rstn), .phy_mode_in(mode), .ext_port_address_in(sec),
    .mac_mdc_in(!mode & m_clk), .mac_mdo_in(m_dat), .mac_mdo_en_in(!mode & m_en), .mac_mdin_out(mdin),
    .emb_mdc_out(), .emb_mdio_out(), .emb_mdio_in(b), .link_up_in(lk), .speed_100_in(sp),
    .full_duplex_in(dx), .mdc_in(mdc_w), .mdc_out(mdc_o), .mdc_oe_n_out(mdc_oen), .mdio_in(mdio_w),
    .mdio_out(mdio_o), .mdio_oe_n_out(mdio_oen), .ext_media_addr_out(ea), .phy_mode_out(mode_o));
  smm_sta_model u_sta (.clk_in(clk), .rd_in(mode ? mdio_w : mdin), .mdc_out(m_clk), .dat_out(m_dat),
    .en_out(m_en), .win_out(m_win));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [16:0] exp_stat(input logic l);
    logic [15:0] s;
    s = smm_pkg::STATUS_BASE;
    s[smm_pkg::STATUS_LINK_BIT] = l;
    return {1'b0, s};
  endfunction
  task automatic rd(input logic [4:0] ra, input logic [16:0] e);
    logic [16:0] q;
    u_sta.frame(smm_pkg::OP_READ, ea, ra, 16'h0000, q);
    cmp(q, e);
  endtask
  // hang guard, frames cost about a thousand cycles each
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    logic [16:0] r;
    logic [15:0] w, ctl;
    void'($urandom(32'h3208));
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      rstn = 1'b0;
      mode = m[0];
      sec = 5'($urandom % 16);
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      cmp({12'h000, ea}, {12'h000, mode ? {sec[4:1], 1'b0} : sec});
      cmp({16'h0000, mode_o}, {16'h0000, mode});
      ctl = smm_pkg::CTRL_RESET;
      repeat (3) begin
        b = 1'($urandom);
        lk = 1'($urandom);
        sp = 1'($urandom);
        dx = 1'($urandom);
        u_sta.frame(smm_pkg::OP_READ, smm_pkg::EMB_PHY_ADDR, 5'($urandom), 16'h0000, r);
        cmp(r, {17{b}});
        u_sta.frame(smm_pkg::OP_READ, mode ? ea | 5'h01 : sec, smm_pkg::REG_STATUS, 16'h0000, r);
        cmp(r, mode ? 17'h1FFFF : {17{!b}});
        if (mode) begin
          w = 16'($urandom) & 16'h7FFF;
          rd(smm_pkg::REG_CTRL, {1'b0, ctl});
          u_sta.frame(smm_pkg::OP_WRITE, ea, smm_pkg::REG_CTRL, w, r);
          ctl = w;
          rd(smm_pkg::REG_STATUS, exp_stat(lk));
          rd(smm_pkg::REG_SPECIAL, {15'h0000, sp, dx});
        end
      end
      $display("mode %0d test done", m);
    end
    final_report();
  end
endmodule // testbench
`default_nettype wire
